// >>> rtl/bcfg_pkg.sv
// Constants shared by the bridge configuration, interrupt and power block.
package bcfg_pkg;
	// Clock rate and printed times.
	localparam int unsigned CLK_KHZ    = 200000;
	localparam int unsigned LVL_W1_MS  = 1;
	localparam int unsigned LVL_W5_MS  = 5;
	localparam int unsigned LVL_W30_MS = 30;
	localparam int unsigned IDLE_MS    = 5000;
	localparam int unsigned SLOW_KHZ   = 30;
	localparam int unsigned LVL_W1_CYC  = LVL_W1_MS * CLK_KHZ;
	localparam int unsigned LVL_W5_CYC  = LVL_W5_MS * CLK_KHZ;
	localparam int unsigned LVL_W30_CYC = LVL_W30_MS * CLK_KHZ;
	localparam int unsigned IDLE_CYC    = IDLE_MS * CLK_KHZ;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PSUS = 8'h04;
	localparam logic [7:0] OFF_TGT  = 8'h08;
	localparam logic [7:0] OFF_DESC = 8'h0c;
	localparam logic [7:0] OFF_STS  = 8'h10;
	localparam logic [7:0] OFF_IEN  = 8'h14;
	localparam logic [7:0] OFF_ICLR = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;

	// Control register fields.
	localparam int CT_TRIG = 0;
	localparam int CT_WID  = 2;
	localparam int CT_PSAV = 4;
	localparam int CT_CHEN = 5;
	localparam int CT_CPOL = 6;
	localparam int CT_WKEN = 7;
	localparam logic [7:0] CTRL_RST = 8'hba;

	// Target register fields.
	localparam int TG_ADDR  = 0;
	localparam int TG_TRIG  = 8;
	localparam int TG_IDLE  = 10;
	localparam int TG_PROT  = 11;
	localparam int TG_PWR   = 12;
	localparam int TG_SUBC  = 13;
	localparam int TG_PCODE = 14;
	localparam logic [15:0] TGT_RST  = 16'h0000;
	localparam logic [15:0] DESC_RST = 16'h0000;

	// Interrupt status bits.
	localparam int IB_WAKE = 0;
	localparam int IB_TGT  = 1;
	localparam int IB_SLOW = 2;
	localparam int IRQ_W   = 3;

	// Trigger and suspend mode codes.
	localparam logic [1:0] TRIG_RISE = 2'h0;
	localparam logic [1:0] TRIG_FALL = 2'h1;
	localparam logic [1:0] TRIG_HIGH = 2'h2;
	localparam logic [1:0] TRIG_LOW  = 2'h3;
	localparam logic [1:0] SUS_KEEP  = 2'h0;
	localparam logic [1:0] SUS_FLOAT = 2'h1;
	localparam logic [1:0] SUS_LOW   = 2'h2;
	localparam logic [1:0] SUS_HIGH  = 2'h3;
endpackage

// >>> rtl/trig_if.sv
// Interface between the configuration block and a trigger detector.
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
	logic        level;
	logic [1:0]  mode;
	logic [31:0] width_cyc;
	logic        hit;
	modport det (input level, input mode, input width_cyc, output hit);
	modport ctl (output level, output mode, output width_cyc, input hit);
endinterface
`default_nettype wire

// >>> rtl/trig_det.sv
// Edge or level trigger detector with a level width qualifier.
`timescale 1ns/1ps
`default_nettype none
module trig_det (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Detector side of the link.
	trig_if.det       t
);
	logic        prev_q;
	logic        prev_d;
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        hit_q;
	logic        hit_d;
	logic        act;

	// Edge cases look at the previous sample; level cases count cycles at the active level.
	always_comb begin
		prev_d = t.level;
		act    = (t.mode == bcfg_pkg::TRIG_HIGH) ? t.level : ~t.level;
		cnt_d  = cnt_q;
		hit_d  = 1'b0;
		unique case (t.mode)
			bcfg_pkg::TRIG_RISE: begin
				hit_d = t.level & ~prev_q;
			end
			bcfg_pkg::TRIG_FALL: begin
				hit_d = ~t.level & prev_q;
			end
			bcfg_pkg::TRIG_HIGH, bcfg_pkg::TRIG_LOW: begin
				if (!act) begin
					cnt_d = 32'h0000_0000;
				end else if (cnt_q <= t.width_cyc) begin
					cnt_d = cnt_q + 32'h0000_0001;
					hit_d = (cnt_q == t.width_cyc);
				end
			end
		endcase
	end

	// Registers only; the counter saturates so one active period fires once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
			cnt_q  <= 32'h0000_0000;
			hit_q  <= 1'b0;
		end else begin
			prev_q <= prev_d;
			cnt_q  <= cnt_d;
			hit_q  <= hit_d;
		end
	end

	assign t.hit = hit_q;
endmodule // trig_det
`default_nettype wire

// >>> rtl/bcfg_ctrl.sv
// Bridge configuration, wake and target interrupt detection, power saving and suspend pin control.
`timescale 1ns/1ps
`default_nettype none
module bcfg_ctrl #(
	parameter int unsigned NPINS    = 6,
	parameter int unsigned W1_CYC   = bcfg_pkg::LVL_W1_CYC,
	parameter int unsigned W5_CYC   = bcfg_pkg::LVL_W5_CYC,
	parameter int unsigned W30_CYC  = bcfg_pkg::LVL_W30_CYC,
	parameter int unsigned IDLE_CYC = bcfg_pkg::IDLE_CYC
) (
	// Clock and reset.
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Asynchronous pins.
	input  wire logic                 irq_wake_pin,
	input  wire logic                 tgt_int_pin,
	// Same-clock status from the rest of the bridge.
	input  wire logic                 activity,
	input  wire logic                 suspend,
	input  wire logic                 charger_detected,
	// Normal pin functions and the pins as driven.
	input  wire logic [NPINS-1:0]     func_out,
	input  wire logic [NPINS-1:0]     func_oe,
	output logic [NPINS-1:0]          pin_out,
	output logic [NPINS-1:0]          pin_oe,
	// Indicators and controls.
	output logic                      charger_detect_indicator,
	output logic                      clk_slow_sel,
	output logic                      irq,
	// Target configuration.
	output logic                      tgt_present,
	output logic [6:0]                tgt_addr,
	output logic [15:0]               tgt_desc_addr,
	output logic [2:0]                tgt_opt_sup,
	output logic                      tgt_boot_subclass,
	output logic [1:0]                tgt_protocol
);
	typedef enum logic {PS_RUN, PS_SLOW} ps_state_t;

	logic                   pready_q, pready_d;
	logic                   pslverr_q, pslverr_d;
	logic [31:0]            prdata_q, prdata_d;
	logic [7:0]             ctrl_q, ctrl_d;
	logic [2*NPINS-1:0]     psus_q, psus_d;
	logic [15:0]            tgt_q, tgt_d;
	logic [15:0]            desc_q, desc_d;
	logic [bcfg_pkg::IRQ_W-1:0] sts_q, sts_d;
	logic [bcfg_pkg::IRQ_W-1:0] ien_q, ien_d;
	logic                   irq_q, irq_d;
	logic                   tpres_q, tpres_d;
	logic                   chg_q, chg_d;
	logic [1:0]             s1_q, s2_q, s3_q, f_q;
	logic [1:0]             s1_d, s2_d, s3_d, f_d;
	logic [1:0]             agree;
	ps_state_t              ps_q, ps_d;
	logic [31:0]            idle_q, idle_d;
	logic [NPINS-1:0]       pout_q, pout_d;
	logic [NPINS-1:0]       poe_q, poe_d;
	logic                   setup, wr;
	logic [bcfg_pkg::IRQ_W-1:0] ev;

	trig_if wake_t ();
	trig_if tgt_t ();

	// Known offsets; anything else answers with an error.
	function automatic logic mapped(input logic [7:0] a);
		return a == bcfg_pkg::OFF_CTRL || a == bcfg_pkg::OFF_PSUS || a == bcfg_pkg::OFF_TGT ||
			a == bcfg_pkg::OFF_DESC || a == bcfg_pkg::OFF_STS || a == bcfg_pkg::OFF_IEN ||
			a == bcfg_pkg::OFF_ICLR || a == bcfg_pkg::OFF_STAT;
	endfunction

	// Level width select; the spare code falls back to the longest width.
	function automatic logic [31:0] width_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: return W1_CYC[31:0];
			2'h1: return W5_CYC[31:0];
			default: return W30_CYC[31:0];
		endcase
	endfunction

	// Pin drive in suspend, returned as {oe, out}.
	function automatic logic [1:0] sus_drive(input logic [1:0] m, input logic s, input logic fo, input logic fe);
		if (!s) begin
			return {fe, fo};
		end
		unique case (m)
			bcfg_pkg::SUS_KEEP:  return {fe, fo};
			bcfg_pkg::SUS_FLOAT: return 2'h0;
			bcfg_pkg::SUS_LOW:   return 2'h2;
			bcfg_pkg::SUS_HIGH:  return 2'h3;
		endcase
	endfunction

	// Read mux, also used at setup time so the access phase has data ready.
	function automatic logic [31:0] rd_val(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			bcfg_pkg::OFF_CTRL: v[7:0] = ctrl_q;
			bcfg_pkg::OFF_PSUS: v[2*NPINS-1:0] = psus_q;
			bcfg_pkg::OFF_TGT:  v[15:0] = tgt_q;
			bcfg_pkg::OFF_DESC: v[15:0] = desc_q;
			bcfg_pkg::OFF_STS:  v[bcfg_pkg::IRQ_W-1:0] = sts_q;
			bcfg_pkg::OFF_IEN:  v[bcfg_pkg::IRQ_W-1:0] = ien_q;
			bcfg_pkg::OFF_STAT: v[3:0] = {f_q[1], tpres_q, ps_q == PS_SLOW, f_q[0]};
			default:            v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// APB: answer in the first access cycle, every transfer takes two cycles.
	always_comb begin
		setup     = psel & ~penable;
		wr        = psel & penable & pready_q & pwrite & ~pslverr_q;
		pready_d  = setup;
		pslverr_d = setup & ~mapped(paddr);
		prdata_d  = (setup & ~pwrite) ? rd_val(paddr) : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Configuration registers written by software.
	always_comb begin
		ctrl_d  = ctrl_q;
		psus_d  = psus_q;
		tgt_d   = tgt_q;
		desc_d  = desc_q;
		ien_d   = ien_q;
		tpres_d = tgt_q[bcfg_pkg::TG_ADDR +: 7] != 7'h00;
		if (wr) begin
			unique case (paddr)
				bcfg_pkg::OFF_CTRL: ctrl_d = pwdata[7:0];
				bcfg_pkg::OFF_PSUS: psus_d = pwdata[2*NPINS-1:0];
				bcfg_pkg::OFF_TGT:  tgt_d = pwdata[15:0];
				bcfg_pkg::OFF_DESC: desc_d = pwdata[15:0];
				bcfg_pkg::OFF_IEN:  ien_d = pwdata[bcfg_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= bcfg_pkg::CTRL_RST;
			psus_q  <= '0;
			tgt_q   <= bcfg_pkg::TGT_RST;
			desc_q  <= bcfg_pkg::DESC_RST;
			ien_q   <= '0;
			tpres_q <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			psus_q  <= psus_d;
			tgt_q   <= tgt_d;
			desc_q  <= desc_d;
			ien_q   <= ien_d;
			tpres_q <= tpres_d;
		end
	end

	// Three-stage sync; the filtered level moves only when stages two and three agree.
	always_comb begin
		s1_d  = {tgt_int_pin, irq_wake_pin};
		s2_d  = s1_q;
		s3_d  = s2_q;
		agree = s2_q ~^ s3_q;
		f_d   = (agree & s3_q) | (~agree & f_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			f_q  <= 2'h0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			f_q  <= f_d;
		end
	end

	// Detector hookup; the target line has no width qualifier, so it fires on the first active cycle.
	assign wake_t.level     = f_q[0];
	assign wake_t.mode      = ctrl_q[bcfg_pkg::CT_TRIG +: 2];
	assign wake_t.width_cyc = width_of(ctrl_q[bcfg_pkg::CT_WID +: 2]);
	assign tgt_t.level      = f_q[1];
	assign tgt_t.mode       = tgt_q[bcfg_pkg::TG_TRIG +: 2];
	assign tgt_t.width_cyc  = 32'h0000_0000;

	trig_det u_wake (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (wake_t)
	);

	trig_det u_tgt (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (tgt_t)
	);

	// Idle timer and clock slow-down; any activity or disabling returns to full speed.
	always_comb begin
		ps_d   = ps_q;
		idle_d = idle_q;
		if (activity || !ctrl_q[bcfg_pkg::CT_PSAV]) begin
			idle_d = 32'h0000_0000;
			ps_d   = PS_RUN;
		end else if (ps_q == PS_RUN) begin
			if (idle_q >= IDLE_CYC[31:0] - 32'h0000_0001) begin
				ps_d = PS_SLOW;
			end else begin
				idle_d = idle_q + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q   <= PS_RUN;
			idle_q <= 32'h0000_0000;
		end else begin
			ps_q   <= ps_d;
			idle_q <= idle_d;
		end
	end

	// Sticky status: a new event wins over a clear in the same cycle.
	always_comb begin
		ev          = '0;
		ev[bcfg_pkg::IB_WAKE] = wake_t.hit & ctrl_q[bcfg_pkg::CT_WKEN];
		ev[bcfg_pkg::IB_TGT]  = tgt_t.hit & tpres_q;
		ev[bcfg_pkg::IB_SLOW] = (ps_q == PS_RUN) && (ps_d == PS_SLOW);
		sts_d = sts_q;
		if (wr && paddr == bcfg_pkg::OFF_ICLR) begin
			sts_d = sts_q & ~pwdata[bcfg_pkg::IRQ_W-1:0];
		end
		sts_d = sts_d | ev;
		irq_d = |(sts_q & ien_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_q <= '0;
			irq_q <= 1'b0;
		end else begin
			sts_q <= sts_d;
			irq_q <= irq_d;
		end
	end

	// Per-pin suspend behaviour and the charger indicator.
	generate
		for (genvar i = 0; i < NPINS; i++) begin : g_pin
			assign {poe_d[i], pout_d[i]} = sus_drive(psus_q[2*i +: 2], suspend, func_out[i], func_oe[i]);
		end
	endgenerate

	// A disabled indicator rests at its inactive level so a board pull sees no false detect.
	always_comb begin
		chg_d = ctrl_q[bcfg_pkg::CT_CHEN] ? (charger_detected ^ ctrl_q[bcfg_pkg::CT_CPOL])
			: ctrl_q[bcfg_pkg::CT_CPOL];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pout_q <= '0;
			poe_q  <= '0;
			chg_q  <= 1'b0;
		end else begin
			pout_q <= pout_d;
			poe_q  <= poe_d;
			chg_q  <= chg_d;
		end
	end

	// Outputs, all taken from flip-flops.
	assign prdata                   = prdata_q;
	assign pready                   = pready_q;
	assign pslverr                  = pslverr_q;
	assign pin_out                  = pout_q;
	assign pin_oe                   = poe_q;
	assign charger_detect_indicator = chg_q;
	assign clk_slow_sel             = ps_q == PS_SLOW;
	assign irq                      = irq_q;
	assign tgt_present              = tpres_q;
	assign tgt_addr                 = tgt_q[bcfg_pkg::TG_ADDR +: 7];
	assign tgt_desc_addr            = desc_q;
	assign tgt_opt_sup              = tgt_q[bcfg_pkg::TG_PWR:bcfg_pkg::TG_IDLE];
	assign tgt_boot_subclass        = tgt_q[bcfg_pkg::TG_SUBC];
	assign tgt_protocol             = tgt_q[bcfg_pkg::TG_PCODE +: 2];
endmodule // bcfg_ctrl
`default_nettype wire

// >>> sim/bcfg_ctrl_assertions.sv
// Port-level checks for the configuration, interrupt and power block.
`timescale 1ns/1ps
`default_nettype none
module bcfg_ctrl_assertions #(
	parameter int unsigned NPINS = 6
) (
	// Clock, reset and bus.
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	// Status, pins and outputs.
	input wire logic             activity,
	input wire logic             suspend,
	input wire logic [NPINS-1:0] func_out,
	input wire logic [NPINS-1:0] func_oe,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe,
	input wire logic             clk_slow_sel,
	input wire logic             tgt_present,
	input wire logic [6:0]       tgt_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The bus answers every setup in the next cycle, for one cycle only.
	ready_next_a: assert property (psel && !penable |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr) else $error("no pslverr");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	// The present flag lags the address write, so it is checked once settled.
	tgt_present_a: assert property ($stable(tgt_addr) [*2] |-> tgt_present == (tgt_addr != 7'h00))
		else $error("tgt_present wrong");
	pin_follow_a: assert property (!suspend |=> pin_out == $past(func_out) && pin_oe == $past(func_oe))
		else $error("pins not following function");
	slow_wake_a: assert property (activity |=> !clk_slow_sel) else $error("slow clock kept");
	slow_idle_a: assert property ($rose(clk_slow_sel) |-> !$past(activity) && !$past(activity, 8))
		else $error("slow clock while busy");
endmodule // bcfg_ctrl_assertions
bind bcfg_ctrl bcfg_ctrl_assertions #(.NPINS(NPINS)) chk_i (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .activity, .suspend, .func_out, .func_oe, .pin_out, .pin_oe, .clk_slow_sel, .tgt_present,
	.tgt_addr);
`default_nettype wire

// >>> sim/tgt_model.sv
// Model of the attached target device and its interrupt line.
`timescale 1ns/1ps
`default_nettype none
module tgt_model (
	// Clock and line polarity.
	input  wire logic pclk,
	input  wire logic active_hi,
	// Interrupt line.
	output var logic  int_line
);
	logic act = 1'b0;
	// The line rests at the inactive level so a mode change alone does not look like a trigger.
	assign int_line = act ? active_hi : ~active_hi;
	// Raise the interrupt for n cycles.
	task automatic fire(input int n);
		act <= 1'b1;
		repeat (n) @(posedge pclk);
		act <= 1'b0;
	endtask
endmodule // tgt_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the configuration, interrupt and power block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v, d, seed;
	logic        pready, pslverr, er, wake_pin = 1'b0, tgt_pin, tgt_hi = 1'b1, activity = 1'b1;
	logic        suspend = 1'b0, charger_detected = 1'b0, ind, slow, irq, tgt_present, boot;
	logic [5:0]  func_out = 6'h00, func_oe = 6'h00, pin_out, pin_oe;
	logic [6:0]  tgt_addr;
	logic [15:0] tgt_desc_addr;
	logic [2:0]  tgt_opt_sup;
	logic [1:0]  tgt_protocol, m;
	int          tests_run = 0, n_mismatch = 0, cyc_n = 0;
	always #2.5 pclk = ~pclk;
	// Short counts keep the level and idle timers within a quick run.
	bcfg_ctrl #(.W1_CYC(20), .W5_CYC(50), .W30_CYC(100), .IDLE_CYC(200)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_wake_pin(wake_pin), .tgt_int_pin(tgt_pin),
		.activity, .suspend, .charger_detected, .func_out, .func_oe, .pin_out, .pin_oe,
		.charger_detect_indicator(ind), .clk_slow_sel(slow), .irq, .tgt_present, .tgt_addr, .tgt_desc_addr,
		.tgt_opt_sup, .tgt_boot_subclass(boot), .tgt_protocol);
	tgt_model tm (.pclk, .active_hi(tgt_hi), .int_line(tgt_pin));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Level width in cycles for a width code, as shortened above.
	function automatic int wid(input logic [1:0] c);
		return (c == 2'h0) ? 20 : (c == 2'h1) ? 50 : 100;
	endfunction
	task automatic end_sim();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string s);
		tests_run++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One bus transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wake pin in one trigger mode; a level is broken once to restart its timer.
	task automatic wake(input logic [1:0] tr, input logic [1:0] wd);
		logic act;
		act = (tr == 2'h0 || tr == 2'h2);
		wake_pin <= ~act;
		apb(1'b1, bcfg_pkg::OFF_CTRL, {24'h0, 4'hb, wd, tr});
		cyc(10);
		apb(1'b1, bcfg_pkg::OFF_ICLR, 32'h7);
		cyc(3);
		chk(irq === 1'b0, "wake idle");
		wake_pin <= act;
		if (tr[1]) begin
			cyc(wid(wd) - 5);
			wake_pin <= ~act;
			cyc(2);
			wake_pin <= act;
			cyc(wid(wd) - 5);
			chk(irq === 1'b0, "level too early");
			cyc(20);
		end else begin
			cyc(10);
		end
		chk(irq === 1'b1, "wake irq");
		apb(1'b1, bcfg_pkg::OFF_IEN, 32'h2);
		cyc(2);
		chk(irq === 1'b0, "masked");
		apb(1'b1, bcfg_pkg::OFF_IEN, 32'h3);
		cyc(2);
		chk(irq === 1'b1, "unmasked");
		apb(1'b1, bcfg_pkg::OFF_ICLR, 32'h1);
		cyc(2);
		chk(irq === 1'b0, "cleared");
	endtask
	initial begin
		seed = 32'h0001_04a2;
		cyc(2);
		presetn <= 1'b1;
		// Reset values, then an unmapped word.
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd === (i == 0 ? {24'h0, bcfg_pkg::CTRL_RST} : 32'h0) && er === (i == 8), "reset value");
		end
		apb(1'b1, bcfg_pkg::OFF_STS, 32'hff);
		apb(1'b0, bcfg_pkg::OFF_STS, 32'h0);
		chk(rd === 32'h0, "status written");
		for (int i = 0; i < 6; i++) begin
			v = xs();
			d = xs();
			if (i == 0) v[6:0] = 7'h00;
			v[7] = 1'b0;
			if (v[15:14] == 2'h3) v[15] = 1'b0;
			apb(1'b1, bcfg_pkg::OFF_TGT, {16'h0, v[15:0]});
			apb(1'b1, bcfg_pkg::OFF_DESC, {16'h0, d[15:0]});
			apb(1'b0, bcfg_pkg::OFF_TGT, 32'h0);
			chk(rd === {16'h0, v[15:0]} && tgt_present === (v[6:0] != 7'h00), "target word");
			chk(tgt_addr === v[6:0] && tgt_desc_addr === d[15:0], "target address");
			chk(tgt_opt_sup === v[12:10] && boot === v[13] && tgt_protocol === v[15:14], "target options");
		end
		apb(1'b1, bcfg_pkg::OFF_TGT, 32'h0);
		apb(1'b1, bcfg_pkg::OFF_IEN, 32'h3);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, bcfg_pkg::OFF_CTRL, {24'h0, 8'h9a | {1'b0, c[1], c[0], 5'h0}});
			charger_detected <= c[2];
			cyc(2);
			chk(ind === (c[0] ? c[2] ^ c[1] : c[1]), "charger indicator");
		end
		wake(2'h0, 2'h0);
		wake(2'h1, 2'h0);
		wake(2'h2, 2'h0);
		wake(2'h2, 2'h1);
		wake(2'h3, 2'h2);
		wake_pin <= 1'b0;
		apb(1'b1, bcfg_pkg::OFF_CTRL, 32'hba);
		// Target interrupt in each mode; the last pass has no target attached.
		for (int t = 0; t < 5; t++) begin
			m = 2'(t);
			tgt_hi <= (m == 2'h0 || m == 2'h2);
			apb(1'b1, bcfg_pkg::OFF_TGT, {22'h0, m, (t < 4) ? 8'h2a : 8'h00});
			cyc(10);
			apb(1'b1, bcfg_pkg::OFF_ICLR, 32'h7);
			cyc(3);
			tm.fire(3);
			cyc(10);
			chk(irq === (t < 4), "target irq");
			apb(1'b1, bcfg_pkg::OFF_ICLR, 32'h2);
			cyc(2);
			chk(irq === 1'b0, "target cleared");
		end
		v = xs();
		v[7:0] = 8'he4;
		apb(1'b1, bcfg_pkg::OFF_PSUS, {20'h0, v[11:0]});
		suspend <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			d = xs();
			func_out <= d[5:0];
			func_oe <= d[11:6];
			cyc(2);
			for (int p = 0; p < 6; p++) begin
				m = v[2*p+:2];
				chk(pin_oe[p] === (m == 2'h0 ? d[6+p] : m != 2'h1) && (m == 2'h1 || pin_out[p] === (m == 2'h0 ? d[p] : m[0])), "suspend pin");
			end
		end
		suspend <= 1'b0;
		// Idle timer with power saving on, then off.
		activity <= 1'b0;
		cyc(190);
		chk(slow === 1'b0, "slow too early");
		cyc(20);
		chk(slow === 1'b1, "slow missing");
		apb(1'b0, bcfg_pkg::OFF_STS, 32'h0);
		chk(rd[2] === 1'b1, "slow status");
		// Both pins rest low and no target is attached, so only the slow flag shows here.
		apb(1'b0, bcfg_pkg::OFF_STAT, 32'h0);
		chk(rd === 32'h0000_0002, "slow state word");
		activity <= 1'b1;
		cyc(2);
		chk(slow === 1'b0, "slow kept");
		apb(1'b1, bcfg_pkg::OFF_CTRL, 32'haa);
		activity <= 1'b0;
		cyc(220);
		chk(slow === 1'b0, "slow while disabled");
		end_sim();
	end
	always @(posedge pclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
endmodule // testbench
`default_nettype wire
